//--- src/cmct_pkg.sv
// Package for the core memory cycle timing block: counts and widths.
// Assumes a single 125 MHz system clock; 10 MHz pacing is derived.
`default_nettype none
package cmct_pkg;
    // ==========================================
    // Clocking
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned TICK_HZ = 10_000_000;
    // Divider ratio; 12.5 is not whole, so ticks come at 12 or 13 cycles
    localparam int unsigned TICK_NUM = TICK_HZ / 1_000_000;
    localparam int unsigned TICK_DEN = CLK_HZ / 1_000_000;
    localparam int unsigned ACC_W = 8;
    localparam logic [ACC_W-1:0] ACC_NUM = ACC_W'(TICK_NUM);
    localparam logic [ACC_W-1:0] ACC_DEN = ACC_W'(TICK_DEN);
    localparam logic [ACC_W-1:0] ACC_RST = 8'h00;
    // ==========================================
    // Cycle counter
    localparam int unsigned CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
    localparam logic [CNT_W-1:0] CNT_RELEASE = 4'hd; // Octal 15
    localparam logic [CNT_W-1:0] CNT_LAST = 4'hf;    // Octal 17
    // ==========================================
    // Stack addressing
    localparam int unsigned ADDR_W = 15;
    localparam int unsigned STACK_BIT = 14;          // 16K words per stack
    typedef enum logic [0:0] {
        CMCT_IDLE = 1'b0,
        CMCT_RUN = 1'b1
    } cmct_state_e;
endpackage : cmct_pkg
`default_nettype wire

//--- src/cmct_tick.sv
// Fractional divider making a one-cycle 10 MHz enable pulse.
// Assumes i_clk at the package rate.
`default_nettype none
module cmct_tick (
    input wire logic i_clk,
    input wire logic i_rst,
    output logic o_tick
);
    logic [cmct_pkg::ACC_W-1:0] acc_ff;
    logic [cmct_pkg::ACC_W-1:0] sum;
    wire wrap = (sum >= cmct_pkg::ACC_DEN);
    assign sum = acc_ff + cmct_pkg::ACC_NUM;
    // ==========================================
    // Accumulator
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            acc_ff <= cmct_pkg::ACC_RST;
            o_tick <= 1'b0;
        end else begin
            acc_ff <= wrap ? sum - cmct_pkg::ACC_DEN : sum;
            o_tick <= wrap;
        end
    end
endmodule // cmct_tick
`default_nettype wire

//--- src/cmct_top.sv
// Memory-control cycle timing: cycle counter, stack initiate, release, permit.
// Assumes request, grant and status inputs synchronous to i_clk.
`default_nettype none
module cmct_top (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_access_granted,
    input wire logic i_requester_is_arith,
    input wire logic [cmct_pkg::ADDR_W-1:0] i_address,
    input wire logic i_two_stacks_fitted,
    input wire logic i_parity_with_overtemp_inhibit,
    input wire logic i_hardware_error_busy,
    output logic o_initiate_stack_lower,
    output logic o_initiate_stack_upper,
    output logic o_arith_unit_release,
    output logic o_end_of_cycle_permit,
    output logic o_cycle_active,
    output logic [cmct_pkg::CNT_W-1:0] o_cycle_time_counter
);

    // ==========================================
    // Declarations
    cmct_pkg::cmct_state_e state_ff;
    cmct_pkg::cmct_state_e nxt_state;
    logic [cmct_pkg::CNT_W-1:0] cycle_time_counter_ff;
    logic [cmct_pkg::CNT_W-1:0] nxt_count;
    logic arith_owner_ff;
    logic nxt_arith_owner;

    logic tick;
    logic count_enable;
    logic advance;
    logic at_last;
    logic idle;
    logic permit;
    logic start;
    logic cycle_start_timing_term;
    logic release_hit;

    logic upper_stack_select;
    logic lower_stack_select;
    logic [1:0] stack_select;
    logic [1:0] stack_initiate;

    logic nxt_end_of_cycle_permit;
    logic nxt_cycle_active;

    // ==========================================
    // Pacing
    // One clock only; 10 MHz comes as a one-cycle enable, so no second clock domain
    cmct_tick u_tick (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .o_tick(tick)
    );

    // ==========================================
    // Decode
    // Either inhibit blocks a start and freezes a running count
    assign count_enable = ~i_parity_with_overtemp_inhibit & ~i_hardware_error_busy;
    assign advance = tick & ~idle & count_enable;
    assign at_last = (cycle_time_counter_ff == cmct_pkg::CNT_LAST);
    assign idle = (state_ff == cmct_pkg::CMCT_IDLE);
    // Permit only when idle or at terminal count
    assign permit = idle | at_last;
    assign start = tick & permit & i_access_granted & count_enable;
    assign cycle_start_timing_term = start;
    // Owner is latched at start, so a requester change mid-cycle cannot move the release
    assign nxt_arith_owner = start ? i_requester_is_arith : arith_owner_ff;
    assign release_hit = advance & arith_owner_ff
        & (nxt_count == cmct_pkg::CNT_RELEASE);

    // ==========================================
    // Stack steering
    // Wrap: a single-stack system folds the high address bit away
    assign upper_stack_select = i_address[cmct_pkg::STACK_BIT] & i_two_stacks_fitted;
    assign lower_stack_select = ~upper_stack_select;
    assign stack_select = {upper_stack_select, lower_stack_select};
    // Entry 0 feeds the lower stack, entry 1 the upper one
    for (genvar g = 0; g < 2; g++) begin : g_stack
        assign stack_initiate[g] = cycle_start_timing_term & stack_select[g];
    end

    // ==========================================
    // Next state
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            cmct_pkg::CMCT_IDLE: begin
                if (start) begin
                    nxt_state = cmct_pkg::CMCT_RUN;
                end
            end
            cmct_pkg::CMCT_RUN: begin
                if (advance & at_last & ~start) begin
                    nxt_state = cmct_pkg::CMCT_IDLE;
                end
            end
        endcase
    end

    // ==========================================
    // Next count
    always_comb begin
        nxt_count = cycle_time_counter_ff;
        if (start) begin
            nxt_count = cmct_pkg::CNT_RST;
        end else if (advance) begin
            if (at_last) begin
                nxt_count = cmct_pkg::CNT_RST;
            end else begin
                nxt_count = cycle_time_counter_ff + 4'h1;
            end
        end
    end

    // ==========================================
    // Next status
    // Status levels follow the next state so they line up with the counter copy
    assign nxt_end_of_cycle_permit = (nxt_state == cmct_pkg::CMCT_IDLE)
        | (nxt_count == cmct_pkg::CNT_LAST);
    assign nxt_cycle_active = (nxt_state == cmct_pkg::CMCT_RUN);

    // ==========================================
    // Cycle state
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= cmct_pkg::CMCT_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cycle_time_counter_ff <= cmct_pkg::CNT_RST;
        end else begin
            cycle_time_counter_ff <= nxt_count;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            arith_owner_ff <= 1'b0;
        end else begin
            arith_owner_ff <= nxt_arith_owner;
        end
    end

    // ==========================================
    // Stack initiate
    // The module keeps its own delay-line timing once initiated, so initiate is one pulse
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_initiate_stack_lower <= 1'b0;
        end else begin
            o_initiate_stack_lower <= stack_initiate[0];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_initiate_stack_upper <= 1'b0;
        end else begin
            o_initiate_stack_upper <= stack_initiate[1];
        end
    end

    // ==========================================
    // Release
    // Pulse lands on the edge that shows octal 15 on the counter copy
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_arith_unit_release <= 1'b0;
        end else begin
            o_arith_unit_release <= release_hit;
        end
    end

    // ==========================================
    // Status
    // Permit resets high: an idle controller may take a request at once
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_end_of_cycle_permit <= 1'b1;
        end else begin
            o_end_of_cycle_permit <= nxt_end_of_cycle_permit;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cycle_active <= 1'b0;
        end else begin
            o_cycle_active <= nxt_cycle_active;
        end
    end

    // Counter copy moves with the internal counter, so the two never disagree
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cycle_time_counter <= cmct_pkg::CNT_RST;
        end else begin
            o_cycle_time_counter <= nxt_count;
        end
    end
endmodule // cmct_top
`default_nettype wire

//--- tb/cmct_top_props.sv
// Checker for the cycle timing block, bound to its top module.
// Assumes every port sits in the one i_clk domain.
`default_nettype none
module cmct_top_props (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_access_granted,
    input wire logic [cmct_pkg::ADDR_W-1:0] i_address,
    input wire logic i_two_stacks_fitted,
    input wire logic i_parity_with_overtemp_inhibit,
    input wire logic i_hardware_error_busy,
    input wire logic o_initiate_stack_lower,
    input wire logic o_initiate_stack_upper,
    input wire logic o_arith_unit_release,
    input wire logic o_end_of_cycle_permit,
    input wire logic o_cycle_active,
    input wire logic [cmct_pkg::CNT_W-1:0] o_cycle_time_counter
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // Properties
    wire logic inh = i_parity_with_overtemp_inhibit | i_hardware_error_busy;
    wire logic init = o_initiate_stack_lower | o_initiate_stack_upper;
    wire logic hi = i_address[cmct_pkg::STACK_BIT] & i_two_stacks_fitted;
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // Two inhibited edges, so the lag of the registered copy is covered
    sequence s_frozen;
        inh [*2];
    endsequence
    a_one_stack: assert property (!(init && o_initiate_stack_lower && o_initiate_stack_upper))
        else $error("both stacks initiated");
    a_stack_upper: assert property (o_initiate_stack_upper |-> $past(hi))
        else $error("upper stack not addressed");
    a_stack_lower: assert property (o_initiate_stack_lower |-> !$past(hi))
        else $error("lower stack not addressed");
    a_start_cause: assert property (init |-> o_cycle_time_counter == 4'h0 &&
        $past(i_access_granted && !inh && o_end_of_cycle_permit)) else $error("bad start");
    a_release_at: assert property (o_arith_unit_release |->
        o_cycle_time_counter == cmct_pkg::CNT_RELEASE) else $error("release off count");
    a_permit_last: assert property (o_cycle_active |->
        o_end_of_cycle_permit == (o_cycle_time_counter == cmct_pkg::CNT_LAST))
        else $error("permit off count");
    a_count_step: assert property ($changed(o_cycle_time_counter) |->
        o_cycle_time_counter == $past(o_cycle_time_counter) + 4'h1) else $error("bad step");
    a_count_frozen: assert property (s_frozen |=> $stable(o_cycle_time_counter))
        else $error("count moved while inhibited");
    a_idle_zero: assert property (!o_cycle_active |-> o_cycle_time_counter == 4'h0)
        else $error("idle count not zero");
endmodule // cmct_top_props
bind cmct_top cmct_top_props u_cmct_top_props (.*);
`default_nettype wire

//--- tb/cmct_requester.sv
// Requesting user device: holds its grant until the cycle is initiated.
// Assumes the bench pulses i_want; i_repeat keeps the grant for a second cycle.
`default_nettype none
module cmct_requester (
    input wire logic i_clk,
    input wire logic i_want,
    input wire logic i_repeat,
    input wire logic i_init,
    output logic o_grant
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_grant = 1'b0;
    always @(posedge i_clk) begin
        o_grant <= i_want | (o_grant & ~(i_init & ~i_repeat));
    end
endmodule // cmct_requester
`default_nettype wire

//--- tb/cmct_top_test.sv
// Self-checking bench: stacks, cycle length, release, restart, inhibits.
// Assumes the requester model supplies the grant.
`default_nettype none
module cmct_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, want = 0, rep = 0, arith = 0, fit = 0, par = 0, hwe = 0;
    logic [cmct_pkg::ADDR_W-1:0] addr = '0;
    logic gnt, ilo, iup, rls, perm, act;
    logic [3:0] cnt;
    int bad_count = 0, samples_checked = 0, cyc = 0;
    cmct_top u_cmct_top (.i_clk(clk), .i_rst(rst), .i_access_granted(gnt),
        .i_requester_is_arith(arith), .i_address(addr), .i_two_stacks_fitted(fit),
        .i_parity_with_overtemp_inhibit(par), .i_hardware_error_busy(hwe),
        .o_initiate_stack_lower(ilo), .o_initiate_stack_upper(iup),
        .o_arith_unit_release(rls), .o_end_of_cycle_permit(perm),
        .o_cycle_active(act), .o_cycle_time_counter(cnt));
    cmct_requester u_cmct_requester (.i_clk(clk), .i_want(want), .i_repeat(rep),
        .i_init(ilo | iup), .o_grant(gnt));
    initial forever #4 clk = ~clk;
    task automatic chk(input bit ok, input string m);
        samples_checked++;
        if (!ok) begin
            bad_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic final_report;
        if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic go;
        int n;
        @(negedge clk) want = 1;
        @(negedge clk) want = 0;
        for (n = 0; n < 40 && !(ilo | iup); n++) @(negedge clk);
    endtask
    task automatic wait_idle(output int n);
        for (n = 0; n < 300 && act === 1'b1; n++) @(negedge clk);
    endtask
    task automatic t_single(input logic a, input logic f, input logic ar);
        int n, r;
        addr = {a, 14'h0123};
        fit = f;
        arith = ar;
        go();
        chk(iup === (a & f) && ilo === !(a & f), "stack");
        r = 0;
        for (n = 0; n < 300 && act === 1'b1; n++) begin
            @(negedge clk) r += int'(rls === 1'b1);
        end
        chk(n > 190 && n < 210, "length");
        chk(r == int'(ar), "release");
        chk(cnt === 4'h0 && perm === 1'b1, "idle");
    endtask
    task automatic t_b2b;
        int n;
        addr = '0;
        rep = 1;
        go();
        @(negedge clk) rep = 0;
        for (n = 0; n < 300 && ilo !== 1'b1; n++) @(negedge clk);
        chk(n > 188 && n < 210 && cnt === 4'h0, "restart");
        wait_idle(n);
    endtask
    task automatic t_inhib;
        logic [3:0] c;
        int n;
        hwe = 1;
        go();
        chk(!(ilo | iup), "inhibited start");
        @(negedge clk) hwe = 0;
        for (n = 0; n < 40 && ilo !== 1'b1; n++) @(negedge clk);
        chk(ilo === 1'b1, "no start after inhibit");
        repeat (50) @(negedge clk);
        par = 1;
        repeat (2) @(negedge clk);
        c = cnt;
        repeat (60) @(negedge clk);
        chk(cnt === c && act === 1'b1, "freeze");
        par = 0;
        wait_idle(n);
    endtask
    // Ceiling well above the roughly 1600 cycles the scenarios need
    always @(posedge clk) if (++cyc == 5000) begin
        bad_count++;
        $display("CHECK FAILED %0t timeout", $time);
        final_report();
    end
    initial begin
        repeat (3) @(negedge clk);
        rst = 0;
        chk(cnt === 4'h0 && perm === 1'b1 && act === 1'b0, "reset status");
        chk({ilo, iup, rls} === 3'h0, "reset pulses");
        for (int i = 0; i < 4; i++) t_single(i[0], i[1], i[0] ^ i[1]);
        t_b2b();
        t_inhib();
        final_report();
    end
endmodule // cmct_top_test
`default_nettype wire
